// [common/lsmc_regs.svh]
`ifndef LSMC_REGS_SVH
`define LSMC_REGS_SVH
// Register selects on the 3-bit address of the host bus.
`define LSMC_ADDR_RECEIVE_HOLDING  3'h0
`define LSMC_ADDR_TRANSMIT_HOLDING 3'h0
`define LSMC_ADDR_MODEM_CONTROL    3'h4
`define LSMC_ADDR_LINE_STATUS      3'h5
`define LSMC_ADDR_MODEM_STATUS     3'h6
// Line status fields.
`define LSMC_LS_FIFO_ERR   7
`define LSMC_LS_TX_EMPTY   6
`define LSMC_LS_HOLD_EMPTY 5
`define LSMC_LS_BREAK      4
`define LSMC_LS_FRAMING    3
`define LSMC_LS_PARITY     2
`define LSMC_LS_OVERRUN    1
`define LSMC_LS_DATA_READY 0
// Modem control fields.
`define LSMC_MC_CLK_SEL    7
`define LSMC_MC_CTL_TRIG_EN 6
`define LSMC_MC_XON_ANY    5
`define LSMC_MC_LOOPBACK   4
`define LSMC_MC_IRQ_EN     3
`define LSMC_MC_FIFO_RDY   2
`define LSMC_MC_RTS        1
`define LSMC_MC_DTR        0
`define LSMC_MC_PROT_MASK  8'hE0
`define LSMC_MC_RESET      8'h00
// Receive FIFO geometry.
`define LSMC_FIFO_DEPTH    64
`define LSMC_PTR_W         6
`endif

// [common/lsmc_pkg.sv]
`default_nettype none
package lsmc_pkg;
  typedef logic [7:0] lsmc_byte_t;
  typedef logic [2:0] lsmc_err_t;
  typedef enum logic [1:0] {
    LSMC_RX_IDLE = 2'b01,
    LSMC_RX_BUSY = 2'b10
  } lsmc_rx_state_t;
endpackage : lsmc_pkg
`default_nettype wire

// [hdl/lsmc_rx_fifo.sv]
`timescale 1ns/100ps
`default_nettype none
`include "lsmc_regs.svh"
module lsmc_rx_fifo (
  // Clock and reset.
  input  wire logic                 sys_clk,
  input  wire logic                 reset,
  // Write side.
  input  wire logic                 wr_en,
  input  wire lsmc_pkg::lsmc_byte_t wr_data,
  input  wire lsmc_pkg::lsmc_err_t  wr_err,
  // Read side.
  input  wire logic                 rd_en,
  output logic                      not_empty,
  output logic                      full,
  output lsmc_pkg::lsmc_byte_t      head_data,
  output lsmc_pkg::lsmc_err_t       head_err,
  output logic                      any_err
);
  localparam int D = `LSMC_FIFO_DEPTH;
  lsmc_pkg::lsmc_byte_t     mem_q [D];
  lsmc_pkg::lsmc_err_t      err_q [D];
  logic [`LSMC_PTR_W-1:0]   rd_q;
  logic [`LSMC_PTR_W-1:0]   wr_q;
  logic [`LSMC_PTR_W:0]     cnt_q;
  logic [D-1:0]             flag_q;
  logic                     do_wr;
  logic                     do_rd;

  assign full      = (cnt_q == (`LSMC_PTR_W+1)'(D));
  assign not_empty = (cnt_q != '0);
  assign do_rd     = rd_en && not_empty;
  assign do_wr     = wr_en && !full;
  assign head_data = mem_q[rd_q];
  assign head_err  = err_q[rd_q];
  assign any_err   = |flag_q;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rd_q  <= '0;
      wr_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (do_wr) wr_q <= wr_q + 1'b1;
      if (do_rd) rd_q <= rd_q + 1'b1;
      cnt_q <= cnt_q + (`LSMC_PTR_W+1)'(do_wr) - (`LSMC_PTR_W+1)'(do_rd);
    end
  end

  // Each entry keeps its error bits; a flag per slot tracks live flagged entries.
  genvar i;
  for (i = 0; i < D; i++) begin : g_slot
    always_ff @(posedge sys_clk) begin
      if (reset) begin
        flag_q[i] <= 1'b0;
      end else if (do_wr && wr_q == `LSMC_PTR_W'(i)) begin
        flag_q[i] <= |wr_err;
      end else if (do_rd && rd_q == `LSMC_PTR_W'(i)) begin
        flag_q[i] <= 1'b0;
      end
    end
    always_ff @(posedge sys_clk) begin
      if (do_wr && wr_q == `LSMC_PTR_W'(i)) begin
        mem_q[i] <= wr_data;
        err_q[i] <= wr_err;
      end
    end
  end
endmodule : lsmc_rx_fifo
`default_nettype wire

// [hdl/lsmc_top.sv]
`timescale 1ns/100ps
`default_nettype none
`include "lsmc_regs.svh"
module lsmc_top (
  // Clock and reset.
  input  wire logic                 sys_clk,
  input  wire logic                 reset,
  // Host bus.
  input  wire logic [2:0]           host_addr,
  input  wire logic                 host_rd,
  input  wire logic                 host_wr,
  input  wire lsmc_pkg::lsmc_byte_t host_wdata,
  output lsmc_pkg::lsmc_byte_t      host_rdata,
  // Enhanced feature and flow-control state from the rest of the channel.
  input  wire logic                 enhanced_write_enable,
  input  wire logic                 auto_rts_en,
  input  wire logic                 auto_rts_level_n,
  // Transmitter state and character timing.
  input  wire logic                 transmit_holding_empty,
  input  wire logic                 transmit_shift_empty,
  input  wire logic                 tx_serial,
  input  wire logic                 parity_en,
  input  wire logic                 parity_odd_sel,
  input  wire logic [1:0]           word_len,
  input  wire logic                 bit_tick,
  // Serial and modem pins.
  input  wire logic                 rx_pin,
  input  wire logic                 cts_n_pin,
  input  wire logic                 dsr_n_pin,
  input  wire logic                 ri_n_pin,
  input  wire logic                 cd_n_pin,
  output logic                      rts_n,
  output logic                      dtr_n,
  output logic                      general_output_pin,
  // Interrupt gating.
  input  wire logic                 irq_request,
  output logic                      irq_out_o,
  output logic                      irq_out_oe,
  // Control outputs to the rest of the channel.
  output logic                      clk_div4_sel,
  output logic                      ctl_trig_access_en,
  output logic                      xon_any_en,
  output logic                      fifo_rdy_en,
  output logic [3:0]                modem_status_lines
);
  lsmc_pkg::lsmc_byte_t     modem_control_q;
  lsmc_pkg::lsmc_byte_t     mc_d;
  lsmc_pkg::lsmc_rx_state_t rx_st_q;
  logic [2:0]               rx_sync_q;
  logic                     rx_level_q;
  logic [3:0]               bit_cnt_q;
  lsmc_pkg::lsmc_byte_t     shift_q;
  logic                     par_q;
  logic                     zeros_q;
  logic                     overrun_q;
  logic [2:0]               cts_s_q;
  logic [2:0]               dsr_s_q;
  logic [2:0]               ri_s_q;
  logic [2:0]               cd_s_q;
  logic [3:0]               pins_q;
  logic                     rx_in;
  logic                     loopback;
  logic                     is_mc_wr;
  logic                     is_ls_rd;
  logic                     is_rh_rd;
  logic                     is_ms_rd;
  logic [3:0]               frame_bits;
  logic                     at_parity;
  logic                     at_stop;
  logic                     push;
  logic                     par_bad;
  logic                     brk;
  lsmc_pkg::lsmc_byte_t     push_data;
  lsmc_pkg::lsmc_err_t      push_err;
  logic                     fifo_ne;
  logic                     fifo_full;
  lsmc_pkg::lsmc_byte_t     head_data;
  lsmc_pkg::lsmc_err_t      head_err;
  logic                     any_err;
  lsmc_pkg::lsmc_byte_t     line_status;
  lsmc_pkg::lsmc_byte_t     modem_status;

  // Bus decode.
  assign is_mc_wr = host_wr && host_addr == `LSMC_ADDR_MODEM_CONTROL;
  assign is_ls_rd = host_rd && host_addr == `LSMC_ADDR_LINE_STATUS;
  assign is_rh_rd = host_rd && host_addr == `LSMC_ADDR_RECEIVE_HOLDING;
  assign is_ms_rd = host_rd && host_addr == `LSMC_ADDR_MODEM_STATUS;

  // Protected upper bits keep their value unless writes are enabled.
  assign mc_d = enhanced_write_enable ? host_wdata
              : ((host_wdata & ~`LSMC_MC_PROT_MASK) | (modem_control_q & `LSMC_MC_PROT_MASK));

  always_ff @(posedge sys_clk) begin
    if (reset) modem_control_q <= `LSMC_MC_RESET;
    else if (is_mc_wr) modem_control_q <= mc_d;
  end

  assign loopback          = modem_control_q[`LSMC_MC_LOOPBACK];
  assign clk_div4_sel      = modem_control_q[`LSMC_MC_CLK_SEL];
  assign ctl_trig_access_en = modem_control_q[`LSMC_MC_CTL_TRIG_EN];
  assign xon_any_en        = modem_control_q[`LSMC_MC_XON_ANY];
  assign fifo_rdy_en       = modem_control_q[`LSMC_MC_FIFO_RDY];

  // Loopback holds rts_n and dtr_n inactive so the line is isolated.
  assign rts_n = loopback ? 1'b1
               : auto_rts_en ? auto_rts_level_n : ~modem_control_q[`LSMC_MC_RTS];
  assign dtr_n = loopback ? 1'b1 : ~modem_control_q[`LSMC_MC_DTR];
  assign general_output_pin = ~modem_control_q[`LSMC_MC_IRQ_EN];
  assign irq_out_oe = modem_control_q[`LSMC_MC_IRQ_EN];
  assign irq_out_o  = irq_request;

  // Pins pass three flops; a change is taken once stages two and three agree.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rx_sync_q  <= 3'h7;
      cts_s_q    <= 3'h7;
      dsr_s_q    <= 3'h7;
      ri_s_q     <= 3'h7;
      cd_s_q     <= 3'h7;
      rx_level_q <= 1'b1;
      pins_q     <= 4'h0;
    end else begin
      rx_sync_q <= {rx_sync_q[1:0], rx_pin};
      cts_s_q   <= {cts_s_q[1:0], cts_n_pin};
      dsr_s_q   <= {dsr_s_q[1:0], dsr_n_pin};
      ri_s_q    <= {ri_s_q[1:0], ri_n_pin};
      cd_s_q    <= {cd_s_q[1:0], cd_n_pin};
      if (rx_sync_q[2] == rx_sync_q[1]) rx_level_q <= rx_sync_q[2];
      if (cd_s_q[2] == cd_s_q[1]) pins_q[3] <= ~cd_s_q[2];
      if (ri_s_q[2] == ri_s_q[1]) pins_q[2] <= ~ri_s_q[2];
      if (dsr_s_q[2] == dsr_s_q[1]) pins_q[1] <= ~dsr_s_q[2];
      if (cts_s_q[2] == cts_s_q[1]) pins_q[0] <= ~cts_s_q[2];
    end
  end

  assign rx_in = loopback ? tx_serial : rx_level_q;
  // Order CD, RI, DSR, CTS.
  assign modem_status_lines = loopback ? {modem_control_q[`LSMC_MC_IRQ_EN], modem_control_q[`LSMC_MC_FIFO_RDY],
                                          modem_control_q[`LSMC_MC_DTR], modem_control_q[`LSMC_MC_RTS]}
                                       : pins_q;
  assign modem_status = {modem_status_lines, 4'h0};

  // Character receiver: one step per bit_tick at mid-bit; the start bit is taken in idle and count 1 is the first data bit.
  assign frame_bits = 4'h5 + {2'b00, word_len};
  assign at_parity  = parity_en && bit_cnt_q == frame_bits + 4'h1;
  assign at_stop    = bit_cnt_q == frame_bits + 4'h1 + {3'b000, parity_en};
  assign push       = rx_st_q == lsmc_pkg::LSMC_RX_BUSY && bit_tick && at_stop;
  assign brk        = zeros_q && !rx_in;
  // The parity bit itself is folded into par_q, so a good frame leaves it equal to the odd select.
  assign par_bad    = parity_en && (par_q != parity_odd_sel);
  assign push_data  = brk ? 8'h00 : (shift_q >> (4'h8 - frame_bits));
  assign push_err   = {brk, !rx_in, par_bad && !brk};

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rx_st_q    <= lsmc_pkg::LSMC_RX_IDLE;
      bit_cnt_q  <= 4'h0;
      shift_q    <= 8'h00;
      par_q      <= 1'b0;
      zeros_q    <= 1'b1;
    end else begin
      case (rx_st_q)
        lsmc_pkg::LSMC_RX_IDLE: begin
          if (bit_tick && !rx_in) begin
            rx_st_q   <= lsmc_pkg::LSMC_RX_BUSY;
            bit_cnt_q <= 4'h1;
            par_q     <= 1'b0;
            zeros_q   <= 1'b1;
          end
        end
        lsmc_pkg::LSMC_RX_BUSY: begin
          if (bit_tick) begin
            bit_cnt_q <= bit_cnt_q + 4'h1;
            par_q     <= par_q ^ rx_in;
            if (rx_in) zeros_q <= 1'b0;
            if (!at_parity && !at_stop) shift_q <= {rx_in, shift_q[7:1]};
            if (at_stop) rx_st_q <= lsmc_pkg::LSMC_RX_IDLE;
          end
        end
        default: rx_st_q <= lsmc_pkg::LSMC_RX_IDLE;
      endcase
    end
  end

  // Overrun: a character finished while the FIFO is full; cleared by a status read.
  always_ff @(posedge sys_clk) begin
    if (reset) overrun_q <= 1'b0;
    else if (push && fifo_full) overrun_q <= 1'b1;
    else if (is_ls_rd) overrun_q <= 1'b0;
  end

  lsmc_rx_fifo u_rx_fifo (
    .sys_clk   (sys_clk),
    .reset     (reset),
    .wr_en     (push),
    .wr_data   (push_data),
    .wr_err    (push_err),
    .rd_en     (is_rh_rd),
    .not_empty (fifo_ne),
    .full      (fifo_full),
    .head_data (head_data),
    .head_err  (head_err),
    .any_err   (any_err)
  );

  // Head error bits go straight to the read data with no holding register.
  assign line_status = {any_err,
                        transmit_holding_empty && transmit_shift_empty,
                        transmit_holding_empty,
                        fifo_ne ? head_err : 3'h0,
                        overrun_q,
                        fifo_ne};

  // Unmapped reads return zero; only a receive holding read pops the FIFO.
  assign host_rdata = is_ls_rd ? line_status
                    : is_ms_rd ? modem_status
                    : is_rh_rd ? head_data
                    : (host_rd && host_addr == `LSMC_ADDR_MODEM_CONTROL) ? modem_control_q
                    : 8'h00;
endmodule : lsmc_top
`default_nettype wire

// [tb/lsmc_checker.sv]
`timescale 1ns/100ps
`default_nettype none
module lsmc_checker (
  // Clock and reset.
  input wire logic                 sys_clk,
  input wire logic                 reset,
  // Host bus.
  input wire logic                 host_rd,
  input wire logic                 host_wr,
  input wire logic [2:0]           host_addr,
  input wire lsmc_pkg::lsmc_byte_t host_wdata,
  input wire lsmc_pkg::lsmc_byte_t host_rdata,
  // Channel state.
  input wire logic                 enhanced_write_enable,
  input wire logic                 auto_rts_en,
  input wire logic                 transmit_holding_empty,
  input wire logic                 transmit_shift_empty,
  input wire logic                 irq_request,
  // Pins and control outputs.
  input wire logic                 irq_out_o,
  input wire logic                 irq_out_oe,
  input wire logic                 rts_n,
  input wire logic                 dtr_n,
  input wire logic                 general_output_pin,
  input wire logic                 clk_div4_sel,
  input wire logic                 ctl_trig_access_en,
  input wire logic                 xon_any_en,
  input wire logic                 fifo_rdy_en,
  input wire logic [3:0]           modem_status_lines
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);
  logic mc_wr;
  logic ls_rd;
  assign mc_wr = host_wr && host_addr == 3'h4;
  assign ls_rd = host_rd && host_addr == 3'h5;
  a_gpo_pin_inverse: assert property (general_output_pin == !irq_out_oe)
    else $error("output pin not inverse of irq enable");
  a_irq_out_gate: assert property (irq_out_oe |-> irq_out_o == irq_request)
    else $error("irq output not following request");
  a_protect_top_bits: assert property (mc_wr && !enhanced_write_enable |=>
    $stable({clk_div4_sel, ctl_trig_access_en, xon_any_en})) else $error("protected bits changed");
  a_top_bits_write: assert property (mc_wr && enhanced_write_enable |=>
    {clk_div4_sel, ctl_trig_access_en, xon_any_en} == $past(host_wdata[7:5])) else $error("top bits not written");
  a_low_bits_write: assert property (mc_wr |=>
    {fifo_rdy_en, irq_out_oe} == $past({host_wdata[2], host_wdata[3]})) else $error("low bits not written");
  a_dtr_drive: assert property (mc_wr && !host_wdata[4] |=> dtr_n == !$past(host_wdata[0]))
    else $error("dtr level wrong");
  a_rts_drive: assert property (mc_wr && !host_wdata[4] ##1 !auto_rts_en |-> rts_n == !$past(host_wdata[1]))
    else $error("rts level wrong");
  a_loop_status: assert property (mc_wr && host_wdata[4] |=>
    modem_status_lines == $past({host_wdata[3:2], host_wdata[0], host_wdata[1]})) else $error("loop status wrong");
  a_tx_empty_bits: assert property (ls_rd |->
    host_rdata[6:5] == {transmit_holding_empty && transmit_shift_empty, transmit_holding_empty})
    else $error("transmit empty bits wrong");
  a_err_summary: assert property (ls_rd && host_rdata[4:2] != 3'h0 |-> host_rdata[7])
    else $error("error summary missing");
  a_empty_no_err: assert property (ls_rd && !host_rdata[0] |-> host_rdata[7] == 1'b0 && host_rdata[4:2] == 3'h0)
    else $error("errors shown on empty fifo");
  c_loopback: cover property (mc_wr && host_wdata[4]);
  c_break_seen: cover property (ls_rd && host_rdata[4]);
  c_overrun_seen: cover property (ls_rd && host_rdata[1]);
endmodule : lsmc_checker
bind lsmc_top lsmc_checker chk_u (.sys_clk(sys_clk), .reset(reset), .host_rd(host_rd), .host_wr(host_wr),
  .enhanced_write_enable(enhanced_write_enable), .auto_rts_en(auto_rts_en), .host_addr(host_addr),
  .host_wdata(host_wdata), .host_rdata(host_rdata), .transmit_holding_empty(transmit_holding_empty),
  .transmit_shift_empty(transmit_shift_empty), .irq_request(irq_request), .irq_out_o(irq_out_o),
  .irq_out_oe(irq_out_oe), .rts_n(rts_n), .dtr_n(dtr_n), .general_output_pin(general_output_pin),
  .clk_div4_sel(clk_div4_sel), .ctl_trig_access_en(ctl_trig_access_en), .xon_any_en(xon_any_en),
  .fifo_rdy_en(fifo_rdy_en), .modem_status_lines(modem_status_lines));
`default_nettype wire

// [tb/lsmc_modem_model.sv]
`timescale 1ns/100ps
`default_nettype none
module lsmc_modem_model (
  // Timing reference.
  input wire logic       sys_clk,
  // Serial data and its mid-bit strobe.
  output var logic       ser_line,
  output var logic       bit_tick,
  // Handshake pins {cd, ri, dsr, cts}, active low.
  output var logic [3:0] pins_n
);
  initial begin
    ser_line = 1'b1;
    bit_tick = 1'b0;
    pins_n = 4'hF;
  end
  // Eight cycles a bit; the strobe comes late so the three-flop synchroniser has settled.
  task automatic put_bit(input logic b);
    ser_line = b;
    repeat (6) @(posedge sys_clk);
    #1 bit_tick = 1'b1;
    @(posedge sys_clk);
    #1 bit_tick = 1'b0;
    @(posedge sys_clk);
    #1;
  endtask : put_bit
  // Eight data bits, even parity, one stop bit, then one idle bit; a zero byte with bad stop is a break.
  task automatic send(input lsmc_pkg::lsmc_byte_t d, input logic bad_par, input logic bad_stop);
    put_bit(1'b0);
    for (int i = 0; i < 8; i++) put_bit(d[i]);
    put_bit(^d ^ bad_par);
    put_bit(!bad_stop);
    put_bit(1'b1);
  endtask : send
  task automatic set_pins(input logic [3:0] v);
    pins_n = v;
  endtask : set_pins
endmodule : lsmc_modem_model
`default_nettype wire

// [tb/test_uart_line_status_modem_control.sv]
`timescale 1ns/100ps
`default_nettype none
module test_uart_line_status_modem_control;
  logic                 sys_clk, reset, host_rd, host_wr, ewe, are, arl, the, tse, pen, podd, irq, loop_sel;
  logic                 rts_n, dtr_n, gpo, io, ioe, c7, c6, c5, c2, ser_line, bit_tick, rx_pin, tx_serial;
  logic [1:0]           wl;
  logic [2:0]           host_addr;
  logic [3:0]           msl, pins_n;
  lsmc_pkg::lsmc_byte_t host_wdata, host_rdata, mc, d, d2, w, exp_ls;
  lsmc_pkg::lsmc_byte_t sent [$];
  lsmc_pkg::lsmc_byte_t rx_dat [4] = '{8'h3C, 8'h00, 8'h5A, 8'hA5};
  lsmc_pkg::lsmc_err_t  rx_err [4] = '{3'h1, 3'h6, 3'h2, 3'h0};
  int                   error_cnt, compares, seed;
  // In loopback the outside line is held low, so any leak would show up as a break.
  assign rx_pin = loop_sel ? 1'b0 : ser_line;
  assign tx_serial = loop_sel ? ser_line : 1'b1;
  lsmc_top dut_u (.sys_clk(sys_clk), .reset(reset), .host_addr(host_addr), .host_rd(host_rd), .host_wr(host_wr),
    .host_wdata(host_wdata), .host_rdata(host_rdata), .enhanced_write_enable(ewe), .auto_rts_en(are),
    .auto_rts_level_n(arl), .transmit_holding_empty(the), .transmit_shift_empty(tse), .tx_serial(tx_serial),
    .parity_en(pen), .parity_odd_sel(podd), .word_len(wl), .bit_tick(bit_tick), .rx_pin(rx_pin),
    .cts_n_pin(pins_n[0]), .dsr_n_pin(pins_n[1]), .ri_n_pin(pins_n[2]), .cd_n_pin(pins_n[3]), .rts_n(rts_n),
    .dtr_n(dtr_n), .general_output_pin(gpo), .irq_request(irq), .irq_out_o(io), .irq_out_oe(ioe),
    .clk_div4_sel(c7), .ctl_trig_access_en(c6), .xon_any_en(c5), .fifo_rdy_en(c2), .modem_status_lines(msl));
  lsmc_modem_model mdl_u (.sys_clk(sys_clk), .ser_line(ser_line), .bit_tick(bit_tick), .pins_n(pins_n));
  always #2.5 sys_clk = ~sys_clk;
  task automatic chk(input lsmc_pkg::lsmc_byte_t got, input lsmc_pkg::lsmc_byte_t exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk
  // Expected line status from the error bits, overrun and fill state the scenario has set up.
  function automatic lsmc_pkg::lsmc_byte_t ls_exp(input logic err_any, input lsmc_pkg::lsmc_err_t e,
      input logic ovr, input logic ne);
    return {err_any, the & tse, the, e, ovr, ne};
  endfunction : ls_exp
  task automatic rd(input logic [2:0] a, output lsmc_pkg::lsmc_byte_t v);
    host_addr = a;
    host_rd = 1'b1;
    @(posedge sys_clk);
    v = host_rdata;
    #1 host_rd = 1'b0;
    @(posedge sys_clk);
    #1;
  endtask : rd
  task automatic wr(input lsmc_pkg::lsmc_byte_t v, input logic ew);
    host_addr = 3'h4;
    host_wdata = v;
    ewe = ew;
    host_wr = 1'b1;
    @(posedge sys_clk);
    #1 host_wr = 1'b0;
    @(posedge sys_clk);
    #1;
    mc = ew ? v : {mc[7:5], v[4:0]};
  endtask : wr
  task automatic test_done;
    $display("compares %0d, mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : test_done
  initial begin
    repeat (40000) @(posedge sys_clk);
    error_cnt++;
    test_done();
  end
  initial begin
    {sys_clk, reset, host_rd, host_wr, ewe, are, arl, irq, loop_sel, podd} = 10'h100;
    {the, tse, pen, wl, host_addr, host_wdata, mc} = 24'hF8_0000;
    seed = 24;
    repeat (12) @(posedge sys_clk);
    #1 reset = 1'b0;
    rd(3'h5, d);
    chk(d, 8'h60);
    chk({4'h0, rts_n, dtr_n, gpo, ioe}, 8'h0E);
    for (int i = 0; i < 4; i++) begin
      {the, tse} = i[1:0];
      rd(3'h5, d);
      chk({6'h0, d[6:5]}, {6'h0, &i[1:0], i[1]});
    end
    for (int i = 0; i < 24; i++) begin
      w = 8'($random(seed));
      {are, arl, irq} = 3'($random(seed));
      mdl_u.set_pins(4'($random(seed)));
      wr(w, i[0]);
      repeat (3) @(posedge sys_clk);
      #1;
      rd(3'h4, d);
      chk(d, mc);
      chk({c7, c6, c5, c2, rts_n, dtr_n, gpo, ioe}, {mc[7:5], mc[2], mc[4] | (are ? arl : ~mc[1]),
        mc[4] | ~mc[0], ~mc[3], mc[3]});
      chk({3'h0, io, msl}, {3'h0, irq, mc[4] ? {mc[3:2], mc[0], mc[1]} : ~pins_n});
    end
    wr(8'h00, 1'b1);
    {the, tse, are} = 3'h6;
    mdl_u.send(rx_dat[0], 1'b1, 1'b0);
    mdl_u.send(rx_dat[1], 1'b0, 1'b1);
    wr(8'h10, 1'b0);
    loop_sel = 1'b1;
    mdl_u.send(rx_dat[2], 1'b0, 1'b1);
    mdl_u.send(rx_dat[3], 1'b0, 1'b0);
    loop_sel = 1'b0;
    wr(8'h00, 1'b0);
    for (int k = 0; k < 4; k++) begin
      exp_ls = ls_exp(k < 3, rx_err[k], 1'b0, 1'b1);
      rd(3'h5, d);
      rd(3'h5, d2);
      chk(d, exp_ls);
      chk(d2, exp_ls);
      rd(3'h0, d);
      chk(d, rx_dat[k]);
    end
    rd(3'h5, d);
    chk(d, 8'h60);
    for (int k = 0; k < 65; k++) begin
      w = 8'($random(seed));
      sent.push_back(w);
      mdl_u.send(w, 1'b0, 1'b0);
    end
    rd(3'h5, d);
    chk(d, 8'h63);
    rd(3'h5, d);
    chk(d, 8'h61);
    for (int k = 0; k < 64; k++) begin
      rd(3'h0, d);
      chk(d, sent[k]);
    end
    rd(3'h5, d);
    chk(d, 8'h60);
    // The model sends even parity unless bad_par is set, so an odd-parity receiver must flag it.
    podd = 1'b1;
    mdl_u.send(8'hC3, 1'b0, 1'b0);
    rd(3'h5, d);
    chk(d, ls_exp(1'b1, 3'h1, 1'b0, 1'b1));
    rd(3'h0, d);
    chk(d, 8'hC3);
    test_done();
  end
endmodule : test_uart_line_status_modem_control
`default_nettype wire
